// ---- core/usb_ep_map.vh ----
// Purpose: Register indices, field positions and reset values of the endpoint block
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef USB_EP_MAP_VH
`define USB_EP_MAP_VH
`define PADDR_W          18
`define IDX_IN_CTRL_H    16'hDE12
`define IDX_OUT_MAX      16'hDE13
`define IDX_OUT_CTRL_L   16'hDE14
`define IDX_EP_SELECT    16'hDE30
`define IDX_IN_MAX       16'hDE31
`define IDX_IN_READY     16'hDE32
`define IDX_BYTE_COUNT   16'hDE33
`define IDX_IRQ_STATUS   16'hDE34
`define IDX_IRQ_CLEAR    16'hDE35
`define IDX_IRQ_ENABLE   16'hDE36
`define IN_AUTO_BIT      7
`define IN_ISO_BIT       6
`define IN_RSV_HI        5
`define IN_RSV_LO        4
`define IN_FORCE_BIT     3
`define IN_DBL_BIT       0
`define IN_CTRL_RESET    8'h20
`define IN_CTRL_WMASK    8'hF9
`define OUT_TOGZ_BIT     7
`define OUT_SSENT_BIT    6
`define OUT_SSTALL_BIT   5
`define OUT_FLUSH_BIT    4
`define OUT_OVR_BIT      2
`define OUT_RDY_BIT      0
`define OUT_MAX_RESET    8'h00
`define EP_SELECT_RESET  3'h1
`define IRQ_OUT_LSB      5
`endif

// ---- core/usb_endpoint_ctrl_status.v ----
// Purpose: Control and status of USB endpoints 1 to 5 (IN high, OUT max size, OUT low)
// Assumes: Event inputs come from the USB engine on clk_in, one event class per cycle
// Notes:   APB slave, zero wait states, read data captured in the setup cycle
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`include "usb_ep_map.vh"
`default_nettype none
module usb_endpoint_ctrl_status (
  // Clock and reset
  input  wire                  clk_in,
  input  wire                  rst_in,
  // APB slave
  input  wire                  psel_in,
  input  wire                  penable_in,
  input  wire                  pwrite_in,
  input  wire [`PADDR_W-1:0]   paddr_in,
  input  wire [31:0]           pwdata_in,
  output wire                  pready_out,
  output wire                  pslverr_out,
  output reg  [31:0]           prdata_out,
  output wire                  irq_out,
  // USB engine events
  input  wire [2:0]            usb_ep_in,
  input  wire                  in_tx_done_in,
  input  wire                  in_ack_in,
  input  wire                  out_rx_ok_in,
  input  wire                  out_rx_err_in,
  input  wire                  out_stall_sent_in,
  input  wire [5:1]            out_iso_in,
  input  wire [5:1]            out_two_slot_in,
  input  wire [7:0]            out_byte_count_in,
  // Firmware FIFO loading
  input  wire                  in_fifo_wr_in,
  input  wire [2:0]            fifo_ep_in,
  // Endpoint state to the engine
  output wire [5:1]            in_packet_ready_out,
  output wire [5:1]            in_iso_out,
  output wire [5:1]            in_two_slot_out,
  output wire [5:1]            in_toggle_out,
  output wire [5:1]            out_toggle_out,
  output wire [5:1]            out_stall_out,
  output wire [5:1]            out_full_out,
  output wire [5:1]            out_packet_ready_out,
  output reg                   in_flush_out,
  output reg                   out_flush_out,
  output reg  [2:0]            flush_ep_out
);

////////////////////////////////////////////////////////////////////////////////

function hit;
  input [`PADDR_W-1:0] a;
  input [15:0]         idx;
  begin
    hit = (a[`PADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
  end
endfunction

reg  [7:0]  in_ctrl   [1:5];
reg  [7:0]  out_max   [1:5];
reg  [7:0]  in_max    [1:5];
reg  [10:0] in_fill   [1:5];
reg  [1:0]  out_slots [1:5];
reg  [5:1]  in_rdy;
reg  [5:1]  in_tog;
reg  [5:1]  out_tog;
reg  [5:1]  stall_sent;
reg  [5:1]  send_stall;
reg  [5:1]  data_err;
reg  [5:1]  overrun;
reg  [2:0]  ep_sel;
reg  [9:0]  irq_stat;
reg  [9:0]  irq_en;

reg  [5:1]  in_done;
reg  [5:1]  in_flush_ev;
reg  [5:1]  in_auto;
reg  [5:1]  out_inc;
reg  [5:1]  out_pop;
reg  [5:1]  out_flush_ev;
reg  [5:1]  full;
reg  [5:1]  sel;
reg  [5:1]  ev;
reg  [5:1]  fw;
reg  [9:0]  irq_set;
reg  [7:0]  rd_mux;
reg         mapped;
integer     e;
integer     k;

wire        access  = psel_in & penable_in;
wire        wr      = access & pwrite_in;
wire        sel_ok  = (ep_sel >= 3'h1) && (ep_sel <= 3'h5);
wire [2:0]  si      = sel_ok ? ep_sel : 3'h1;

////////////////////////////////////////////////////////////////////////////////
// Bus decode

// Write strobes; those of the endpoint registers are shared by all endpoint copies
wire        wr_in_ctrl  = wr & hit(paddr_in, `IDX_IN_CTRL_H);
wire        wr_out_max  = wr & hit(paddr_in, `IDX_OUT_MAX);
wire        wr_in_max   = wr & hit(paddr_in, `IDX_IN_MAX);
wire        wr_in_ready = wr & hit(paddr_in, `IDX_IN_READY);
wire        wr_out_ctrl = wr & hit(paddr_in, `IDX_OUT_CTRL_L);
wire        wr_select   = wr & hit(paddr_in, `IDX_EP_SELECT);
wire        wr_irq_en   = wr & hit(paddr_in, `IDX_IRQ_ENABLE);
wire        wr_irq_clr  = wr & hit(paddr_in, `IDX_IRQ_CLEAR);
wire [9:0]  irq_clr     = wr_irq_clr ? pwdata_in[9:0] : 10'h000;

assign pready_out  = 1'b1;
assign pslverr_out = access & ~mapped;
assign irq_out     = |(irq_stat & irq_en);

assign in_packet_ready_out  = in_rdy;
assign in_toggle_out        = in_tog;
assign out_toggle_out       = out_tog;

genvar g;
generate
  for (g = 1; g <= 5; g = g + 1) begin : ep_view
    assign in_iso_out[g]           = in_ctrl[g][`IN_ISO_BIT];
    assign in_two_slot_out[g]      = in_ctrl[g][`IN_DBL_BIT];
    // Stalling an isochronous endpoint is not possible
    assign out_stall_out[g]        = send_stall[g] & ~out_iso_in[g];
    assign out_full_out[g]         = full[g];
    assign out_packet_ready_out[g] = (out_slots[g] != 2'h0);
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Per-endpoint events

always @* begin
  irq_set = 10'h000;
  for (e = 1; e <= 5; e = e + 1) begin
    sel[e] = sel_ok && (ep_sel == e[2:0]);
    ev[e]  = (usb_ep_in == e[2:0]);
    fw[e]  = (fifo_ep_in == e[2:0]);
    // Isochronous has no handshake, so any send completes the packet
    in_done[e] = in_tx_done_in & ev[e] &
                 (in_ack_in | in_ctrl[e][`IN_ISO_BIT] | in_ctrl[e][`IN_FORCE_BIT]);
    in_flush_ev[e] = in_tx_done_in & ev[e] & in_ctrl[e][`IN_FORCE_BIT];
    in_auto[e] = in_fifo_wr_in & fw[e] & in_ctrl[e][`IN_AUTO_BIT] &
                 ((in_fill[e] + 11'h001) == {in_max[e], 3'h0});
    full[e] = (out_slots[e] == (out_two_slot_in[e] ? 2'h2 : 2'h1));
    out_inc[e] = out_rx_ok_in & ev[e] & ~full[e] &
                 ~(send_stall[e] & ~out_iso_in[e]);
    out_flush_ev[e] = wr_out_ctrl & sel[e] & pwdata_in[`OUT_FLUSH_BIT] &
                      (out_slots[e] != 2'h0);
    // A flush drops a packet just as an unload does, so both pop a slot
    out_pop[e] = out_flush_ev[e] |
                 (wr_out_ctrl & sel[e] & ~pwdata_in[`OUT_RDY_BIT] &
                  (out_slots[e] != 2'h0));
    irq_set[e-1] = in_done[e];
    irq_set[e+4] = out_inc[e] | (out_stall_sent_in & ev[e]);
  end
end

////////////////////////////////////////////////////////////////////////////////
// Register state

always @(posedge clk_in or posedge rst_in) begin
  if (rst_in) begin
    for (k = 1; k <= 5; k = k + 1) begin
      in_ctrl[k]   <= `IN_CTRL_RESET;
      out_max[k]   <= `OUT_MAX_RESET;
      in_max[k]    <= 8'h00;
      in_fill[k]   <= 11'h000;
      out_slots[k] <= 2'h0;
    end
    in_rdy        <= 5'h00;
    in_tog        <= 5'h00;
    out_tog       <= 5'h00;
    stall_sent    <= 5'h00;
    send_stall    <= 5'h00;
    data_err      <= 5'h00;
    overrun       <= 5'h00;
    ep_sel        <= `EP_SELECT_RESET;
    irq_stat      <= 10'h000;
    irq_en        <= 10'h000;
    in_flush_out  <= 1'b0;
    out_flush_out <= 1'b0;
    flush_ep_out  <= 3'h0;
  end else begin
    in_flush_out  <= |in_flush_ev;
    out_flush_out <= |out_flush_ev;
    if (|in_flush_ev)
      flush_ep_out <= usb_ep_in;
    else if (|out_flush_ev)
      flush_ep_out <= ep_sel;
    if (wr_select)
      ep_sel <= pwdata_in[2:0];
    if (wr_irq_en)
      irq_en <= pwdata_in[9:0];
    // A new event wins over a clear in the same cycle
    irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    for (k = 1; k <= 5; k = k + 1) begin
      if (wr_in_ctrl && sel[k])
        in_ctrl[k] <= pwdata_in[7:0] & `IN_CTRL_WMASK;
      if (wr_out_max && sel[k])
        out_max[k] <= pwdata_in[7:0];
      if (wr_in_max && sel[k])
        in_max[k] <= pwdata_in[7:0];
      // IN side: device clear first, firmware and auto-arm set win
      if (in_done[k]) begin
        in_rdy[k] <= 1'b0;
        in_tog[k] <= ~in_tog[k];
      end
      if (in_auto[k])
        in_fill[k] <= 11'h000;
      else if (in_fifo_wr_in && fw[k])
        in_fill[k] <= in_fill[k] + 11'h001;
      if (in_auto[k])
        in_rdy[k] <= 1'b1;
      if (wr_in_ready && sel[k] && pwdata_in[0]) begin
        in_rdy[k]  <= 1'b1;
        in_fill[k] <= 11'h000;
      end
      // OUT side
      out_slots[k] <= out_slots[k] + {1'b0, out_inc[k]} - {1'b0, out_pop[k]};
      if (out_pop[k])
        data_err[k] <= 1'b0;
      if (out_rx_err_in && ev[k] && out_iso_in[k])
        data_err[k] <= 1'b1;
      if (wr_out_ctrl && sel[k]) begin
        send_stall[k] <= pwdata_in[`OUT_SSTALL_BIT];
        if (!pwdata_in[`OUT_SSENT_BIT])
          stall_sent[k] <= 1'b0;
        if (!pwdata_in[`OUT_OVR_BIT])
          overrun[k] <= 1'b0;
        // Toggle zeroing is a strobe, so the bit never reads back as 1
        if (pwdata_in[`OUT_TOGZ_BIT])
          out_tog[k] <= 1'b0;
      end
      if (out_inc[k])
        out_tog[k] <= ~out_tog[k];
      if (out_stall_sent_in && ev[k])
        stall_sent[k] <= 1'b1;
      if (out_rx_ok_in && ev[k] && full[k] && out_iso_in[k])
        overrun[k] <= 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Read path, captured in the setup cycle so access needs no wait

always @* begin
  mapped = 1'b1;
  rd_mux = 8'h00;
  case (paddr_in[`PADDR_W-1:2])
    `IDX_IN_CTRL_H:  rd_mux = sel_ok ? in_ctrl[si] : 8'h00;
    `IDX_OUT_MAX:    rd_mux = sel_ok ? out_max[si] : 8'h00;
    `IDX_IN_MAX:     rd_mux = sel_ok ? in_max[si] : 8'h00;
    `IDX_OUT_CTRL_L: rd_mux = sel_ok ? {1'b0, stall_sent[si], send_stall[si], 1'b0,
                                        data_err[si], overrun[si], full[si],
                                        (out_slots[si] != 2'h0)} : 8'h00;
    `IDX_IN_READY:   rd_mux = sel_ok ? {7'h00, in_rdy[si]} : 8'h00;
    // Count is only meaningful with a packet waiting
    `IDX_BYTE_COUNT: rd_mux = (sel_ok && out_slots[si] != 2'h0) ?
                              out_byte_count_in : 8'h00;
    `IDX_EP_SELECT:  rd_mux = {5'h00, ep_sel};
    `IDX_IRQ_STATUS: rd_mux = irq_stat[7:0];
    `IDX_IRQ_ENABLE: rd_mux = irq_en[7:0];
    `IDX_IRQ_CLEAR:  rd_mux = 8'h00;
    default:         mapped = 1'b0;
  endcase
  if (paddr_in[1:0] != 2'h0)
    mapped = 1'b0;
end

always @(posedge clk_in or posedge rst_in) begin
  if (rst_in) begin
    prdata_out <= 32'h00000000;
  end else if (psel_in && !penable_in && !pwrite_in) begin
    if (paddr_in[`PADDR_W-1:2] == `IDX_IRQ_STATUS)
      prdata_out <= {22'h000000, irq_stat};
    else if (paddr_in[`PADDR_W-1:2] == `IDX_IRQ_ENABLE)
      prdata_out <= {22'h000000, irq_en};
    else
      prdata_out <= {24'h000000, rd_mux};
  end
end

endmodule
`default_nettype wire

// ---- tb/usb_host_model.sv ----
// Purpose: Host and engine side, turning bus tokens into endpoint events
// Assumes: Tasks are entered just after a rising edge of clk_in
// Notes:   Qualifiers show their inverse after a token; the byte count holds
`timescale 1ns/10ps
`default_nettype none
module usb_host_model (
  input  wire logic       clk_in,
  input  wire logic [5:1] stall_in,
  output logic      [2:0] ep_out,
  output logic            done_out,
  output logic            ack_out,
  output logic            ok_out,
  output logic            err_out,
  output logic            stall_sent_out,
  output logic      [7:0] count_out
);
  initial {ep_out, done_out, ack_out, ok_out, err_out, stall_sent_out, count_out} = '0;
  // Kind 0 IN packet sent, 1 OUT data, 2 OUT data with CRC error
  task automatic token(input logic [2:0] ep, input logic [1:0] kind, input logic ack);
    ep_out <= ep;
    ack_out <= ack;
    count_out <= {ep, 5'h08};
    done_out <= kind == 2'h0;
    ok_out <= kind == 2'h1 && !stall_in[ep];
    err_out <= kind == 2'h2;
    stall_sent_out <= kind == 2'h1 && stall_in[ep];
    @(posedge clk_in);
    {done_out, ok_out, err_out, stall_sent_out} <= 4'h0;
    ep_out <= ~ep;
    ack_out <= ~ack;
    @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// ---- tb/usb_endpoint_ctrl_status_monitor.sv ----
// Purpose: Port-level checks of the endpoint control block
// Assumes: Engine events name endpoints 1 to 5
// Notes:   Bound to every instance of the block
`timescale 1ns/10ps
`default_nettype none
module usb_endpoint_ctrl_status_monitor (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       psel_in,
  input wire logic       penable_in,
  input wire logic       pwrite_in,
  input wire logic [2:0] usb_ep_in,
  input wire logic       in_tx_done_in,
  input wire logic       in_ack_in,
  input wire logic       out_rx_ok_in,
  input wire logic       in_fifo_wr_in,
  input wire logic [5:1] out_iso_in,
  input wire logic [5:1] out_two_slot_in,
  input wire logic [5:1] in_packet_ready_out,
  input wire logic [5:1] in_iso_out,
  input wire logic [5:1] in_two_slot_out,
  input wire logic [5:1] out_stall_out,
  input wire logic [5:1] out_full_out,
  input wire logic [5:1] out_packet_ready_out,
  input wire logic       in_flush_out,
  input wire logic       out_flush_out,
  input wire logic [2:0] flush_ep_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire logic ep_ok = usb_ep_in >= 3'h1 && usb_ep_in <= 3'h5;
  wire logic apb_wr = psel_in && penable_in && pwrite_in;
  a_stall_not_iso:
    assert property ((out_stall_out & out_iso_in) == 5'h00) else $error("stall on iso endpoint");
  a_full_has_packet:
    assert property ((out_full_out & ~out_packet_ready_out) == 5'h00) else $error("full but empty");
  a_one_slot_full:
    assert property ((out_packet_ready_out & ~out_two_slot_in & ~out_full_out) == 5'h00)
    else $error("single slot holds a packet but not full");
  a_rx_sets_ready:
    assert property (out_rx_ok_in && ep_ok && !out_stall_out[usb_ep_in]
      && !out_full_out[usb_ep_in] |=> out_packet_ready_out[$past(usb_ep_in)])
    else $error("received packet not flagged ready");
  a_in_sent_clears:
    assert property (in_tx_done_in && in_ack_in && ep_ok && !in_two_slot_out[usb_ep_in]
      && !in_fifo_wr_in && !apb_wr |=> !in_packet_ready_out[$past(usb_ep_in)])
    else $error("sent IN packet still ready");
  a_in_flush_cause:
    assert property (in_flush_out |-> $past(in_tx_done_in) && flush_ep_out == $past(usb_ep_in))
    else $error("IN flush without finished transfer");
  a_out_flush_cause:
    assert property (out_flush_out |-> $past(apb_wr)) else $error("OUT flush without write");
  a_type_by_write:
    assert property ($changed({in_iso_out, in_two_slot_out}) |-> $past(apb_wr))
    else $error("IN type changed without write");
endmodule
bind usb_endpoint_ctrl_status usb_endpoint_ctrl_status_monitor i_monitor (
  .clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .usb_ep_in, .in_tx_done_in,
  .in_ack_in, .out_rx_ok_in, .in_fifo_wr_in, .out_iso_in, .out_two_slot_in,
  .in_packet_ready_out, .in_iso_out, .in_two_slot_out, .out_stall_out, .out_full_out,
  .out_packet_ready_out, .in_flush_out, .out_flush_out, .flush_ep_out);
`default_nettype wire

// ---- tb/tb_usb_endpoint_ctrl_status.sv ----
// Purpose: Self-checking bench of the endpoint control block
// Assumes: Zero-wait APB slave, host model on the engine side
// Notes:   Endpoint under test and OUT max sizes are random, seed fixed
`timescale 1ns/10ps
`default_nettype none
`include "usb_ep_map.vh"
module tb_usb_endpoint_ctrl_status;
  logic clk_in, rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, irq_out, err;
  logic in_tx_done_in, in_ack_in, out_rx_ok_in, out_rx_err_in, out_stall_sent_in;
  logic in_fifo_wr_in, in_flush_out, out_flush_out;
  logic [2:0] usb_ep_in, fifo_ep_in, flush_ep_out, ep;
  logic [`PADDR_W-1:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rdata;
  logic [7:0] out_byte_count_in, v [1:5];
  logic [5:1] out_iso_in, out_two_slot_in, in_packet_ready_out, in_iso_out, in_two_slot_out;
  logic [5:1] in_toggle_out, out_toggle_out, out_stall_out, out_full_out, out_packet_ready_out;
  int failures = 0, checks_done = 0, cycles = 0, seed, e;
  // Room of one endpoint FIFO in 8-byte units, a plain default
  localparam int fifo_units = 64;
  usb_endpoint_ctrl_status i_usb_endpoint_ctrl_status (.clk_in, .rst_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .pslverr_out, .prdata_out, .irq_out,
    .usb_ep_in, .in_tx_done_in, .in_ack_in, .out_rx_ok_in, .out_rx_err_in, .out_stall_sent_in,
    .out_iso_in, .out_two_slot_in, .out_byte_count_in, .in_fifo_wr_in, .fifo_ep_in,
    .in_packet_ready_out, .in_iso_out, .in_two_slot_out, .in_toggle_out, .out_toggle_out,
    .out_stall_out, .out_full_out, .out_packet_ready_out, .in_flush_out, .out_flush_out,
    .flush_ep_out);
  usb_host_model i_usb_host_model (.clk_in, .stall_in(out_stall_out), .ep_out(usb_ep_in),
    .done_out(in_tx_done_in), .ack_out(in_ack_in), .ok_out(out_rx_ok_in),
    .err_out(out_rx_err_in), .stall_sent_out(out_stall_sent_in), .count_out(out_byte_count_in));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  // Request held until pready is seen at an edge, then one idle edge
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, wr, idx, 2'b00, wd};
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    rdata = prdata_out;
    err = pslverr_out;
    {psel_in, penable_in} <= 2'b00;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(rdata, exp);
  endtask
  task automatic load(input int n);
    fifo_ep_in <= ep;
    in_fifo_wr_in <= 1'b1;
    repeat (n) @(posedge clk_in);
    in_fifo_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  function automatic logic [31:0] irq_bit(input logic [2:0] n, input logic out);
    return 32'h1 << (int'(n) - 1 + (out ? `IRQ_OUT_LSB : 0));
  endfunction
  initial begin
    {rst_in, psel_in, penable_in, pwrite_in, in_fifo_wr_in, paddr_in, pwdata_in} = '0;
    rst_in = 1'b1;
    {out_iso_in, out_two_slot_in, fifo_ep_in} = 13'h0001;
    seed = 46;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(`IDX_IN_CTRL_H, 32'h20);
    rd(`IDX_OUT_MAX, 32'h00);
    for (e = 1; e <= 5; e++) begin
      v[e] = 8'($unsigned($random(seed)) % (fifo_units + 1));
      wr(`IDX_EP_SELECT, e);
      wr(`IDX_OUT_MAX, {24'h0, v[e]});
    end
    for (e = 5; e >= 0; e--) begin
      wr(`IDX_EP_SELECT, e);
      rd(`IDX_OUT_MAX, e == 0 ? 32'h0 : {24'h0, v[e]});
    end
    apb(1'b0, 16'hDE3F, 32'h0);
    check(err, 1'b1);
    $display("test register copies done");
    ep = 3'(1 + $unsigned($random(seed)) % 5);
    wr(`IDX_EP_SELECT, {29'h0, ep});
    wr(`IDX_IRQ_ENABLE, 32'h3FF);
    i_usb_host_model.token(ep, 2'h1, 1'b0);
    rd(`IDX_OUT_CTRL_L, 32'h03);
    rd(`IDX_BYTE_COUNT, {24'h0, ep, 5'h08});
    check(irq_out, 1'b1);
    rd(`IDX_IRQ_STATUS, irq_bit(ep, 1'b1));
    wr(`IDX_OUT_CTRL_L, 32'h81);
    check(out_toggle_out[ep], 1'b0);
    rd(`IDX_OUT_CTRL_L, 32'h03);
    wr(`IDX_IRQ_CLEAR, irq_bit(ep, 1'b1));
    check(irq_out, 1'b0);
    wr(`IDX_OUT_CTRL_L, 32'h00);
    rd(`IDX_OUT_CTRL_L, 32'h00);
    rd(`IDX_BYTE_COUNT, 32'h0);
    wr(`IDX_OUT_CTRL_L, 32'h20);
    check(out_stall_out[ep], 1'b1);
    i_usb_host_model.token(ep, 2'h1, 1'b0);
    rd(`IDX_OUT_CTRL_L, 32'h60);
    check(irq_out, 1'b1);
    wr(`IDX_OUT_CTRL_L, 32'h00);
    rd(`IDX_OUT_CTRL_L, 32'h00);
    out_iso_in[ep] <= 1'b1;
    wr(`IDX_OUT_CTRL_L, 32'h20);
    check(out_stall_out[ep], 1'b0);
    wr(`IDX_OUT_CTRL_L, 32'h00);
    // An errored packet is not stored, so only the error flag shows
    i_usb_host_model.token(ep, 2'h2, 1'b0);
    rd(`IDX_OUT_CTRL_L, 32'h08);
    repeat (2) i_usb_host_model.token(ep, 2'h1, 1'b0);
    rd(`IDX_OUT_CTRL_L, 32'h0F);
    wr(`IDX_OUT_CTRL_L, 32'h00);
    rd(`IDX_OUT_CTRL_L, 32'h00);
    {out_iso_in[ep], out_two_slot_in[ep]} <= 2'b01;
    repeat (2) i_usb_host_model.token(ep, 2'h1, 1'b0);
    rd(`IDX_OUT_CTRL_L, 32'h03);
    for (e = 1; e >= 0; e--) begin
      wr(`IDX_OUT_CTRL_L, 32'h11);
      rd(`IDX_OUT_CTRL_L, {31'h0, e[0]});
    end
    $display("test out path done");
    wr(`IDX_IRQ_CLEAR, 32'h3FF);
    wr(`IDX_IN_CTRL_H, 32'h28);
    check({in_iso_out[ep], in_two_slot_out[ep]}, 2'h0);
    wr(`IDX_IN_READY, 32'h1);
    check(in_packet_ready_out[ep], 1'b1);
    i_usb_host_model.token(ep, 2'h0, 1'b1);
    check(in_packet_ready_out[ep], 1'b0);
    check(in_toggle_out[ep], 1'b1);
    rd(`IDX_IRQ_STATUS, irq_bit(ep, 1'b0));
    wr(`IDX_IN_CTRL_H, 32'hE1);
    check({in_iso_out[ep], in_two_slot_out[ep]}, 2'h3);
    rd(`IDX_IN_CTRL_H, 32'hE1);
    wr(`IDX_IN_MAX, 32'h1);
    load(7);
    check(in_packet_ready_out[ep], 1'b0);
    load(1);
    check(in_packet_ready_out[ep], 1'b1);
    $display("test in path done");
    summarize();
  end
endmodule
`default_nettype wire
